// ==== hdl/plcs_pkg.sv ====
// Package: offsets, field positions, reset values and codes for the link control/status register
package plcs_pkg;
  // Register location
  localparam logic [11:0] LINK_CTRL_STAT_OFS = 12'h0d0;
  localparam logic [31:0] LINK_CTRL_STAT_RST = 32'h0041_0000;
  // Field positions
  localparam int DL_ACTIVE_BIT = 29;
  localparam int SLOT_CLK_BIT = 28;
  localparam int LANE_LSB = 20;
  localparam int RATE_LSB = 16;
  localparam int EXT_SYNC_BIT = 7;
  localparam int REFCLK_SEL_BIT = 6;
  localparam int RETRAIN_BIT = 5;
  localparam int LINK_OFF_BIT = 4;
  localparam int RCB_BIT = 3;
  localparam int ASPM_LSB = 0;
  // Reset values and codes
  localparam logic [5:0] LANE_X1 = 6'h01;
  localparam logic [5:0] LANE_X2 = 6'h02;
  localparam logic [5:0] LANE_X4 = 6'h04;
  localparam logic [3:0] RATE_2G5 = 4'h1;
  localparam logic [1:0] ASPM_OFF = 2'h0;
  localparam logic [1:0] ASPM_L0S = 2'h1;
  localparam logic SLOT_CLK_RST = 1'b0;
  // Writable bit mask: bits 7,6,3,1:0
  localparam logic [31:0] WR_MASK = 32'h0000_00cb;
  // Exit latency codes reported for async and common reference clock
  localparam logic [2:0] L0S_EXIT_ASYNC = 3'h3;
  localparam logic [2:0] L0S_EXIT_COMMON = 3'h2;
  // Controller's own Avalon register map (word byte addresses)
  localparam logic [3:0] CTL_CMD_OFS = 4'h0;
  localparam logic [3:0] CTL_WDATA_OFS = 4'h4;
  localparam logic [3:0] CTL_RDATA_OFS = 4'h8;
  localparam logic [3:0] CTL_STAT_OFS = 4'hc;
endpackage

// ==== hdl/plcs_cfg_if.sv ====
// Interface: configuration access path between upstream software port and the register
interface plcs_cfg_if;
  logic req;
  logic wr;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic [3:0] be;
  logic ack;
  logic [31:0] rdata;
  // Bridge end holds the register
  modport dev (input req, wr, addr, wdata, be, output ack, rdata);
  // Upstream controller issues accesses
  modport host (output req, wr, addr, wdata, be, input ack, rdata);
endinterface

// ==== hdl/plcs_link_regs.sv ====
// Link control and status register inside the bridge's capability structure
// Overview of operation
// R1 - Register at 0x0d0, reset 0x0041_0000
// R2 - Data link active bit 29 reads zero
// R3 - Bit 28 reports shared refclk, loadable
// R4 - Bits 25:20 one-hot lane count, reset x4
// R5 - Bits 19:16 rate, 0001 is 2.5G
// R6 - Bit 7 extends synchronization for analyzers
// R7 - Bit 6 selects common reference clock
// R8 - Exit latency follows common clock select
// R9 - Software programs both ends, then retrains
// R10 - Retrain bit 5, disable bit 4 read zero
// R11 - Bit 3 holds completion boundary 64/128
// R12 - Bits 1:0 power management, 01 L0s
// R13 - Reserved positions always read zero
// R14 - Writes to read-only positions ignored
//
// The Avalon-MM register port was decided locally.
module plcs_link_regs (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Configuration access
  plcs_cfg_if.dev cfg,
  // Status from the link core and serial EEPROM loader
  input wire logic [5:0] laneCount,
  input wire logic [3:0] linkRate,
  input wire logic slotClkLoad,
  input wire logic slotClkVal,
  // Controls to the link core
  output logic extSync,
  output logic refclkCommon,
  output logic completion128,
  output logic [1:0] activePm,
  output logic [2:0] l0sExitLatency
);
  // Writable state
  logic extSync_r;
  logic refclkSel_r;
  logic rcb_r;
  logic [1:0] aspm_r;
  // Hardware-fed status, captured so reads are stable
  logic slotClk_r;
  logic [5:0] lane_r;
  logic [3:0] rate_r;
  logic ack_r;
  logic [31:0] rdata_r;
  // Sync stages for link-core status (may come from another clock)
  logic [5:0] laneS1_r;
  logic [3:0] rateS1_r;

  // Access model
  // The upstream controller raises req and holds it until ack; the register
  // answers one edge later with ack and read data together, then drops ack.
  // A write lands on the edge that raises ack, so software sees the new value
  // on the next read with no extra wait.
  // Only byte lane 0 carries writable bits; upper lanes hold status and
  // reserved positions, so their byte enables change nothing.
  // Reserved power-management codes are stored as written; they are not
  // supported, and software is expected to keep to 00 and 01.
  // Status inputs are levels from the link core and are only sampled.

  // Decode: this register hit
  wire hit = cfg.req && (cfg.addr == plcs_pkg::LINK_CTRL_STAT_OFS);
  wire wrLow = hit && cfg.wr && cfg.be[0];
  wire [31:0] regView;

  // Field views, each named so the read word below stays readable
  // Upper reserved pair, never driven by hardware
  wire [1:0] rsvdTop = 2'h0; // R13
  // Link-active reporting is not offered, so the flag is tied low
  wire dlActiveFlag = 1'b0; // R2
  // Shared reference clock flag as loaded at power-up
  wire slotClockShared = slotClk_r; // R3
  // Reserved pair between the clock flag and the lane field
  wire [1:0] rsvdMid = 2'h0; // R13
  // Negotiated lane count, one-hot
  wire [5:0] negotiatedLaneCount = lane_r; // R4
  // Negotiated rate code
  wire [3:0] negotiatedRate = rate_r; // R5
  // Whole reserved byte below the status half
  wire [7:0] rsvdByte = 8'h00; // R13
  // Retrain and disable have no meaning for a bridge
  wire [1:0] retrainOff = 2'h0; // R10
  // Reserved bit between boundary select and power control
  wire rsvdLow = 1'b0; // R13

  // Assemble read view; reserved and tied bits stay zero
  assign regView = {rsvdTop, // R13
                    dlActiveFlag, // R2
                    slotClockShared, // R3
                    rsvdMid, // R13
                    negotiatedLaneCount, // R4
                    negotiatedRate, // R5
                    rsvdByte, // R13
                    extSync_r,
                    refclkSel_r,
                    retrainOff, // R10
                    rcb_r,
                    rsvdLow, // R13
                    aspm_r};

  // Keep read-only and reserved positions, take only writable ones from the bus;
  // masking here means a new writable bit needs a mask change as well as its own flop and write line
  function automatic logic [31:0] mergeWrite(input logic [31:0] held,
                                             input logic [31:0] incoming);
    begin
      mergeWrite = (held & ~plcs_pkg::WR_MASK) | (incoming & plcs_pkg::WR_MASK); // R14
    end
  endfunction

  // Word as it would stand after the write
  wire [31:0] wrMerged = mergeWrite(regView, cfg.wdata);

  // Register storage; only byte 0 holds writable bits
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      extSync_r <= 1'b0; // R1
      refclkSel_r <= 1'b0;
      rcb_r <= 1'b0;
      aspm_r <= plcs_pkg::ASPM_OFF;
      slotClk_r <= plcs_pkg::SLOT_CLK_RST;
    end
    else
    begin
      // Only masked positions change; the rest ignore writes
      if (wrLow)
      begin
        extSync_r <= wrMerged[plcs_pkg::EXT_SYNC_BIT]; // R6
        refclkSel_r <= wrMerged[plcs_pkg::REFCLK_SEL_BIT]; // R7
        rcb_r <= wrMerged[plcs_pkg::RCB_BIT]; // R11
        aspm_r <= wrMerged[plcs_pkg::ASPM_LSB +: 2]; // R12
      end
      // EEPROM loader may set the slot clock bit
      if (slotClkLoad)
        slotClk_r <= slotClkVal; // R3
    end
  end

  // Lane and rate status through two flops
  // The link core may run on its own clock; two stages keep a metastable
  // level out of the read path. Both stages reset to the default codes so a
  // read right after reset shows four lanes at the base rate.
  // Limitation: a multi-bit change may read mixed for one cycle; the codes
  // only move during link training, long before software looks.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      laneS1_r <= plcs_pkg::LANE_X4;
      rateS1_r <= plcs_pkg::RATE_2G5;
      lane_r <= plcs_pkg::LANE_X4; // R4
      rate_r <= plcs_pkg::RATE_2G5; // R5
    end
    else
    begin
      laneS1_r <= laneCount;
      rateS1_r <= linkRate;
      lane_r <= laneS1_r;
      rate_r <= rateS1_r;
    end
  end

  // Handshake: ack one edge after the request is seen, then low for a cycle
  // so a request that is still up is never answered twice
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      ack_r <= 1'b0;
    else
      ack_r <= cfg.req && !ack_r;
  end

  // Read data captured with the ack; unmapped offsets read zero
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      rdata_r <= 32'h0000_0000;
    else
      rdata_r <= hit ? regView : 32'h0000_0000; // R13
  end

  assign cfg.ack = ack_r;
  assign cfg.rdata = rdata_r;
  // Controls out
  assign extSync = extSync_r;
  assign refclkCommon = refclkSel_r;
  assign completion128 = rcb_r;
  assign activePm = aspm_r;
  // Common clock shortens the reported exit latency
  assign l0sExitLatency = refclkSel_r ? plcs_pkg::L0S_EXIT_COMMON
                                      : plcs_pkg::L0S_EXIT_ASYNC; // R8
endmodule

// ==== hdl/plcs_upstream_ctl.sv ====
// Upstream controller: Avalon-MM slave that issues configuration accesses
module plcs_upstream_ctl (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Configuration access
  plcs_cfg_if.host cfg
);
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_BUSY = 2'b10} plcs_state_e;
  plcs_state_e state_r;
  logic [13:0] cmd_r; // [13] write, [12] go, [11:0] offset
  logic [31:0] wdata_r;
  logic [31:0] rdata_r;
  logic done_r;
  logic [31:0] avsRd_r;
  logic avsAck_r;

  wire avReq = (avs_read || avs_write) && !avsAck_r;
  // Transfer is taken only at the edge where waitrequest is low
  wire avTake = (avs_read || avs_write) && avsAck_r;
  wire goCmd = avTake && avs_write && (avs_address == plcs_pkg::CTL_CMD_OFS);

  // Register access, answered one cycle after the request
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      avsAck_r <= 1'b0;
      avsRd_r <= 32'h0000_0000;
      cmd_r <= 14'h0000;
      wdata_r <= 32'h0000_0000;
    end
    else
    begin
      avsAck_r <= avReq;
      if (avTake && avs_write && avs_address == plcs_pkg::CTL_WDATA_OFS)
        wdata_r <= avs_writedata;
      else if (goCmd)
        cmd_r <= {avs_writedata[13], 1'b1, avs_writedata[11:0]};
      if (avs_address == plcs_pkg::CTL_CMD_OFS)
        avsRd_r <= {18'h0, cmd_r};
      else if (avs_address == plcs_pkg::CTL_WDATA_OFS)
        avsRd_r <= wdata_r;
      else if (avs_address == plcs_pkg::CTL_RDATA_OFS)
        avsRd_r <= rdata_r;
      else if (avs_address == plcs_pkg::CTL_STAT_OFS)
        avsRd_r <= {30'h0, done_r, state_r == ST_BUSY};
      else
        avsRd_r <= 32'h0000_0000;
    end
  end

  // Access sequencer; software must set refclk select on both ends, then retrain (R9)
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      rdata_r <= 32'h0000_0000;
      done_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
          if (goCmd)
          begin
            state_r <= ST_BUSY;
            done_r <= 1'b0;
          end
        ST_BUSY:
          if (cfg.ack)
          begin
            state_r <= ST_IDLE;
            rdata_r <= cfg.rdata;
            done_r <= 1'b1;
          end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !avsAck_r;
  assign avs_readdata = avsRd_r;
  assign cfg.req = (state_r == ST_BUSY) && !cfg.ack;
  assign cfg.wr = cmd_r[13];
  assign cfg.addr = cmd_r[11:0];
  assign cfg.wdata = wdata_r;
  assign cfg.be = 4'hf;
endmodule

// ==== sim/plcs_cfg_checker.sv ====
// Checker: handshake and read values on the configuration path
module plcs_cfg_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Configuration path
  input wire logic req,
  input wire logic wr,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [3:0] be,
  input wire logic ack,
  input wire logic [31:0] rdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Read of the link register, answered one cycle on
  sequence s_rd_link;
    req && !ack && !wr && addr == 12'h0d0 ##1 ack;
  endsequence
  // Read of any other offset
  sequence s_rd_other;
    req && !ack && !wr && addr != 12'h0d0 ##1 ack;
  endsequence
  a_ack_follows: assert property (req && !ack |=> ack) else $error("ack late");
  a_ack_pulse: assert property (ack |=> !ack) else $error("ack too long");
  a_ack_asked: assert property (ack |-> $past(req)) else $error("ack unasked");
  a_addr_held: assert property (req && !ack |=> $stable(addr)) else $error("addr moved");
  a_rsvd_zero: assert property (s_rd_link |-> rdata[31:30] == 2'h0 &&
    rdata[27:26] == 2'h0 && rdata[15:8] == 8'h00 && !rdata[2]) else $error("reserved set");
  a_dl_zero: assert property (s_rd_link |-> !rdata[29]) else $error("dl active");
  a_rt_dis_zero: assert property (s_rd_link |-> rdata[5:4] == 2'h0)
    else $error("retrain set");
  a_other_zero: assert property (s_rd_other |-> rdata == 32'h0)
    else $error("other read");
endmodule

// ==== sim/plcs_link_regs_test.sv ====
// Testbench: software reaches the link register through the controller
module plcs_link_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  // Avalon master side
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wrt = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] q;
  logic [31:0] rv;
  logic wq;
  // Link core status and controls
  logic [5:0] lanes = plcs_pkg::LANE_X4;
  logic [3:0] rate = plcs_pkg::RATE_2G5;
  logic ldSlot = 1'b0;
  logic slotVal = 1'b0;
  logic extSync, refCom, rcb128;
  logic [1:0] pm;
  logic [2:0] lat;
  int errors = 0;
  int comparisons = 0;
  plcs_cfg_if cfg ();
  plcs_upstream_ctl u_plcs_upstream_ctl (.ref_clk(ref_clk), .rst_n(rst_n),
    .avs_address(adr), .avs_read(rd), .avs_write(wrt), .avs_writedata(wd),
    .avs_readdata(q), .avs_waitrequest(wq), .cfg(cfg));
  plcs_link_regs u_plcs_link_regs (.ref_clk(ref_clk), .rst_n(rst_n), .cfg(cfg),
    .laneCount(lanes), .linkRate(rate), .slotClkLoad(ldSlot), .slotClkVal(slotVal),
    .extSync(extSync), .refclkCommon(refCom), .completion128(rcb128), .activePm(pm),
    .l0sExitLatency(lat));
  plcs_cfg_checker u_plcs_cfg_checker (.ref_clk(ref_clk), .rst_n(rst_n), .req(cfg.req),
    .wr(cfg.wr), .addr(cfg.addr), .wdata(cfg.wdata), .be(cfg.be), .ack(cfg.ack),
    .rdata(cfg.rdata));
  // 10 MHz core clock
  always #50 ref_clk = ~ref_clk;
  // Verdict and end of run
  task automatic stop_test();
    if (errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Compare one word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One Avalon transfer, held until waitrequest is seen low
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    adr <= a;
    wd <= d;
    wrt <= w;
    rd <= !w;
    do @(posedge ref_clk); while (wq !== 1'b0);
    rv = q;
    wrt <= 1'b0;
    rd <= 1'b0;
  endtask
  // Configuration access through the controller; read result lands in rv
  task automatic acc(input logic w, input logic [11:0] o, input logic [31:0] d);
    av(1'b1, plcs_pkg::CTL_WDATA_OFS, d);
    av(1'b1, plcs_pkg::CTL_CMD_OFS, {18'h0, w, 1'b0, o});
    rv = 32'h0;
    while (rv[1] !== 1'b1) av(1'b0, plcs_pkg::CTL_STAT_OFS, 32'h0);
    av(1'b0, plcs_pkg::CTL_RDATA_OFS, 32'h0);
  endtask
  // Reset contents and latency for an asynchronous clock
  task automatic t_reset();
    acc(1'b0, 12'h0d0, 32'h0);
    chk(rv, 32'h0041_0000);
    chk(32'({extSync, refCom, rcb128, pm, lat}), 32'h03);
  endtask
  // All ones then L0s only: only writable bits stick
  task automatic t_write();
    acc(1'b1, 12'h0d0, 32'hffff_ffff);
    acc(1'b0, 12'h0d0, 32'h0);
    chk(rv, 32'h0041_00cb);
    chk(32'(rcb128), 32'h1);
    chk(32'({extSync, refCom, rcb128, pm, lat}), 32'hfa);
    acc(1'b1, 12'h0d0, 32'h0000_0001);
    acc(1'b0, 12'h0d0, 32'h0);
    chk(rv, 32'h0041_0001);
    chk(32'({extSync, refCom, rcb128, pm, lat}), 32'h0b);
  endtask
  // Every lane code, with the slot clock bit loaded
  task automatic t_status();
    logic [5:0] tbl [3];
    tbl = '{plcs_pkg::LANE_X1, plcs_pkg::LANE_X2, plcs_pkg::LANE_X4};
    for (int i = 0; i < 3; i++)
    begin
      @(posedge ref_clk);
      lanes <= tbl[i];
      ldSlot <= 1'b1;
      slotVal <= 1'b1;
      @(posedge ref_clk);
      ldSlot <= 1'b0;
      acc(1'b0, 12'h0d0, 32'h0);
      chk(rv, {6'h04, tbl[i], 4'h1, 16'h0001});
      chk(32'(rv[19:16]), 32'(plcs_pkg::RATE_2G5));
    end
  endtask
  // Other offsets and an unmapped Avalon address read zero
  task automatic t_other();
    acc(1'b1, 12'h0d4, 32'hffff_ffff);
    acc(1'b0, 12'h0d4, 32'h0);
    chk(rv, 32'h0);
    av(1'b0, 4'h1, 32'h0);
    chk(rv, 32'h0);
  endtask
  // Main sequence, with a second reset mid-run
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_write();
    t_status();
    t_other();
    rst_n <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    stop_test();
  end
  // Watchdog against a hung handshake
  initial
  begin
    #400000;
    errors++;
    stop_test();
  end
endmodule
